// *** common/bps_pkg.sv ***
// Contract
// - Lock and clear fault within 100 ms
// - Clock-change pulse high 4 to 20 us
// - Bit clock runs at 64 fs
// - Serial data changes on bit clock fall
// - Word clock changes on bit clock fall
// - Serial clocks derive from selected system clock
// - MSB-first I2S, LJ24, RJ24, RJ16 selectable
// - Recovered mode serves 32 to 96 kHz; the 384 and 512 fs ratios fail above about 65 and 48 kHz
// - Decode never needs reference oscillator
// - Separate channel-status and user-bit outputs
// - Serial clocks may run from reference oscillator
// - System clock 128/256/384/512 fs by ratio
// - Source select low recovered, high reference
// - Fault wired to select gives auto switching
// - Reset drives outputs low, fault high
package bps_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_HZ        = 50_000_000;
    localparam int CLK_MHZ       = 50;
    localparam int PULSE_MIN_NS  = 4000;
    localparam int PULSE_MAX_NS  = 20000;
    localparam int PULSE_CYC     = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int PULSE_MAX_CYC = PULSE_MAX_NS * CLK_MHZ / 1000;
    localparam int MIN_FS_HZ     = 28000;
    localparam int DEF_FS_HZ     = 48000;
    localparam int LOSS_CYC      = 2 * CLK_HZ / MIN_FS_HZ;
    localparam int PERIOD_DEF    = CLK_HZ / DEF_FS_HZ;
    localparam int LOCK_FRAMES   = 8;

    // ----------------------------------------------------------------
    // Framing
    // ----------------------------------------------------------------
    localparam int SAMPLE_W      = 24;
    localparam int SUB_BITS      = 28;
    localparam int PRE_HALVES    = 8;
    localparam int ENTRY_W       = 2 * (SAMPLE_W + 2);
    localparam int MEM_DEPTH     = 4;
    localparam logic [1:0] LATENCY = 2'h3;
    localparam logic [1:0] KIND_B  = 2'h1;
    localparam logic [1:0] KIND_W  = 2'h2;
    localparam logic [5:0] OFF_I2S  = 6'h01;
    localparam logic [5:0] OFF_LJ   = 6'h00;
    localparam logic [5:0] OFF_RJ24 = 6'h08;
    localparam logic [5:0] OFF_RJ16 = 6'h10;
    localparam logic [5:0] WID_24   = 6'h18;
    localparam logic [5:0] WID_16   = 6'h10;

    typedef enum logic [1:0] {BPS_FMT_I2S, BPS_FMT_LJ24, BPS_FMT_RJ24, BPS_FMT_RJ16} bps_fmt_e;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int         ADDR_W      = 8;
    localparam logic [5:0] REG_CTRL    = 6'h00;
    localparam logic [5:0] REG_STATUS  = 6'h01;
    localparam logic [5:0] REG_IRQ_ST  = 6'h02;
    localparam logic [5:0] REG_IRQ_MSK = 6'h03;
    localparam logic [5:0] REG_PERIOD  = 6'h04;
    localparam logic [1:0] CTRL_RST    = 2'h0;
    localparam int         IRQ_W       = 3;
    localparam int         IRQ_GAIN    = 0;
    localparam int         IRQ_LOST    = 1;
    localparam int         IRQ_CHG     = 2;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** design/bps_sync.sv ***
`timescale 1ns/100ps
module bps_sync
    import bps_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Asynchronous in, synchronised out
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta     <= '0;
            sync_out <= '0;
        end else begin
            meta     <= async_in;
            sync_out <= meta;
        end
    end

endmodule

// *** design/bps_rx_out.sv ***
// The AXI4-Lite slave port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module bps_rx_out
    import bps_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Pins from outside
    input  wire logic              biphase_in,
    input  wire logic              ref_osc_in,
    input  wire logic              clk_source_sel,
    input  wire logic [1:0]        pll_ratio_sel,
    // Serial audio and status pins
    output logic                   sys_clk_out,
    output logic                   bit_clk_out,
    output logic                   word_clk_out,
    output logic                   serial_data_out,
    output logic                   chan_status_out,
    output logic                   user_bit_out,
    output logic                   lock_fault,
    output logic                   clock_change_pulse,
    output logic                   irq,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [4:0] pins_s;
    logic       bi_d;
    logic       ref_d;
    wire        bi_s    = pins_s[0];
    wire        ref_s   = pins_s[1];
    wire        src_osc = pins_s[2];
    wire  [1:0] ratio_s = pins_s[4:3];

    bps_sync #(.WIDTH(5)) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({pll_ratio_sel, clk_source_sel, ref_osc_in, biphase_in}),
        .sync_out (pins_s)
    );

    // ----------------------------------------------------------------
    // Biphase decoder, runs without the reference
    // ----------------------------------------------------------------
    logic [7:0]          iv;
    logic [7:0]          unit_len;
    logic                in_pre;
    logic                first_pre;
    logic                synced;
    logic                pend;
    logic [3:0]          pre_h;
    logic [1:0]          kind;
    logic [4:0]          nbits;
    logic [SUB_BITS-1:0] sr;
    logic                sub_done;
    wire                 bi_edge = bi_s ^ bi_d;
    wire  [9:0]          t2      = {1'b0, iv, 1'b0};
    wire  [9:0]          u3      = {2'h0, unit_len} + {1'b0, unit_len, 1'b0};
    wire  [9:0]          u5      = {2'h0, unit_len} + {unit_len, 2'h0};
    wire  [1:0]          halves  = (t2 < u3) ? 2'h1 : (t2 < u5) ? 2'h2 : 2'h3;
    wire  [3:0]          pre_sum = pre_h + {2'h0, halves};
    wire                 bit_ok  = bi_edge && !in_pre && synced && halves != 2'h3 && nbits < 5'(SUB_BITS);
    wire                 bit_val = (halves == 2'h1);
    wire                 bit_now = bit_ok && (halves == 2'h2 ? !pend : pend);
    logic                loss;
    logic                timeout;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            iv       <= 8'h00;
            unit_len <= 8'hFF;
            bi_d     <= 1'b0;
        end else begin
            bi_d <= bi_s;
            if (bi_edge) begin
                iv <= 8'h01;
                if (iv < unit_len)
                    unit_len <= iv;
            end else if (iv != 8'hFF)
                iv <= iv + 8'h01;
            if (timeout)
                unit_len <= 8'hFF;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            in_pre    <= 1'b0;
            first_pre <= 1'b0;
            synced    <= 1'b0;
            pend      <= 1'b0;
            pre_h     <= 4'h0;
            kind      <= 2'h0;
            nbits     <= 5'h00;
            sr        <= '0;
            sub_done  <= 1'b0;
        end else begin
            sub_done <= bit_now && nbits == 5'(SUB_BITS - 1);
            if (bi_edge && in_pre) begin
                first_pre <= 1'b0;
                pre_h     <= pre_sum;
                if (first_pre)
                    kind <= halves;
                if (pre_sum >= 4'(PRE_HALVES)) begin
                    in_pre <= 1'b0;
                    synced <= 1'b1;
                    nbits  <= 5'h00;
                    pend   <= 1'b0;
                end
            end else if (bi_edge && halves == 2'h3) begin
                in_pre    <= 1'b1;
                first_pre <= 1'b1;
                pre_h     <= 4'h3;
            end else if (bit_ok) begin
                if (halves == 2'h2 && pend)
                    synced <= 1'b0;
                else if (halves == 2'h1 && !pend)
                    pend <= 1'b1;
                else begin
                    pend  <= 1'b0;
                    sr    <= {bit_val, sr[SUB_BITS-1:1]};
                    nbits <= nbits + 5'h01;
                end
            end
            if (timeout)
                synced <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Frame store, rate measure and lock
    // ----------------------------------------------------------------
    logic [ENTRY_W-1:0]  mem [MEM_DEPTH];
    logic [SAMPLE_W+1:0] left_hold;
    logic [1:0]          wr_ptr;
    logic                frame_evt;
    logic [11:0]         per_cnt;
    logic [11:0]         period;
    logic [2:0]          lock_cnt;
    wire  [SAMPLE_W+1:0] sub_word = {sr[26], sr[25], sr[SAMPLE_W-1:0]};
    wire                 is_right = (kind == KIND_W);
    wire  [1:0]          rd_ptr   = wr_ptr - LATENCY;

    assign timeout = per_cnt > 12'(LOSS_CYC);
    assign loss    = timeout || !synced;

    always_ff @(posedge aclk) begin
        if (sub_done && is_right)
            mem[wr_ptr] <= {left_hold, sub_word};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_hold <= '0;
            wr_ptr    <= 2'h0;
            frame_evt <= 1'b0;
        end else begin
            frame_evt <= sub_done && is_right;
            if (sub_done && !is_right)
                left_hold <= sub_word;
            if (sub_done && is_right)
                wr_ptr <= wr_ptr + 2'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            per_cnt    <= 12'h000;
            period     <= 12'(PERIOD_DEF);
            lock_cnt   <= 3'h0;
            lock_fault <= 1'b1;
        end else begin
            per_cnt <= (frame_evt || timeout) ? 12'h001 : per_cnt + 12'h001;
            if (loss) begin
                lock_cnt   <= 3'h0;
                lock_fault <= 1'b1;
            end else if (frame_evt) begin
                period <= per_cnt;
                if (lock_cnt == 3'(LOCK_FRAMES - 1))
                    lock_fault <= 1'b0;
                else
                    lock_cnt <= lock_cnt + 3'h1;
            end
        end
    end

    // ----------------------------------------------------------------
    // System clock source and ratio
    // ----------------------------------------------------------------
    logic [11:0] acc;
    wire  [11:0] eff_per  = lock_fault ? 12'(PERIOD_DEF) : period;
    wire  [11:0] step     = {1'b0, 3'(ratio_s) + 3'h1, 8'h00};
    wire  [12:0] acc_sum  = {1'b0, acc} + {1'b0, step};
    wire         pll_tick = acc_sum >= {1'b0, eff_per};
    wire         ref_edge = ref_s ^ ref_d;
    wire         sys_tick = src_osc ? ref_edge : pll_tick;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc   <= 12'h000;
            ref_d <= 1'b0;
        end else begin
            ref_d <= ref_s;
            if (step >= eff_per)
                acc <= 12'h000;
            else
                acc <= pll_tick ? 12'(acc_sum - {1'b0, eff_per}) : acc_sum[11:0];
        end
    end

    // ----------------------------------------------------------------
    // Serial audio output
    // ----------------------------------------------------------------
    logic [1:0]         fmt;
    logic [1:0]         fmt_act;
    logic [2:0]         sedge;
    logic [5:0]         bc;
    logic [ENTRY_W-1:0] out_entry;
    wire                bck_edge = sys_tick && sedge == {ratio_s, 1'b1};
    wire                bck_fall = bck_edge && bit_clk_out;
    wire  [5:0]         nbc      = bc + 6'h01;
    wire  [1:0]         fmt_cur  = (nbc == 6'h00) ? fmt : fmt_act;
    wire  [ENTRY_W-1:0] cur      = (nbc == 6'h00) ? mem[rd_ptr] : out_entry;
    wire                ch       = nbc[5];
    wire  [23:0]        word24   = ch ? cur[SAMPLE_W-1:0] : cur[ENTRY_W-3 -: SAMPLE_W];
    wire  [5:0]         off      = (fmt_cur == BPS_FMT_I2S)  ? OFF_I2S  :
                                   (fmt_cur == BPS_FMT_LJ24) ? OFF_LJ   :
                                   (fmt_cur == BPS_FMT_RJ24) ? OFF_RJ24 : OFF_RJ16;
    wire  [5:0]         wid      = (fmt_cur == BPS_FMT_RJ16) ? WID_16 : WID_24;
    wire  [5:0]         pos      = {1'b0, nbc[4:0]} - off;
    wire                pos_ok   = !pos[5] && pos < wid;
    wire  [4:0]         msb_idx  = 5'd23 - pos[4:0];
    wire                live     = !lock_fault;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_clk_out     <= 1'b0;
            bit_clk_out     <= 1'b0;
            word_clk_out    <= 1'b0;
            serial_data_out <= 1'b0;
            chan_status_out <= 1'b0;
            user_bit_out    <= 1'b0;
            sedge           <= 3'h0;
            bc              <= 6'h3F;
            out_entry       <= '0;
            fmt_act         <= CTRL_RST;
        end else if (sys_tick) begin
            sys_clk_out <= ~sys_clk_out;
            sedge       <= bck_edge ? 3'h0 : sedge + 3'h1;
            if (bck_edge)
                bit_clk_out <= ~bit_clk_out;
            if (bck_fall) begin
                bc              <= nbc;
                out_entry       <= cur;
                fmt_act         <= fmt_cur;
                word_clk_out    <= (fmt_cur == BPS_FMT_I2S) ? ch : ~ch;
                serial_data_out <= live && pos_ok && word24[msb_idx];
                chan_status_out <= live && (ch ? cur[SAMPLE_W+1] : cur[ENTRY_W-1]);
                user_bit_out    <= live && (ch ? cur[SAMPLE_W] : cur[ENTRY_W-2]);
            end
        end
    end

    // ----------------------------------------------------------------
    // Clock-change pulse
    // ----------------------------------------------------------------
    logic       src_d;
    logic       lf_d;
    logic [9:0] pulse_cnt;
    wire        chg_evt   = (src_osc != src_d) || (lock_fault != lf_d);
    wire        chg_start = chg_evt && !clock_change_pulse;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            src_d              <= 1'b0;
            lf_d               <= 1'b1;
            pulse_cnt          <= 10'h000;
            clock_change_pulse <= 1'b0;
        end else begin
            src_d <= src_osc;
            lf_d  <= lock_fault;
            if (chg_start) begin
                clock_change_pulse <= 1'b1;
                pulse_cnt          <= 10'(PULSE_CYC - 1);
            end else if (pulse_cnt != 10'h000)
                pulse_cnt <= pulse_cnt - 10'h001;
            else
                clock_change_pulse <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register file and interrupt
    // ----------------------------------------------------------------
    logic [IRQ_W-1:0]  irq_st;
    logic [IRQ_W-1:0]  irq_msk;
    logic              aw_full;
    logic              w_full;
    logic [5:0]        aw_idx;
    logic [31:0]       wdata_h;
    logic              wstrb0_h;
    wire  [IRQ_W-1:0]  irq_set = {chg_start, !lf_d && lock_fault, lf_d && !lock_fault};
    wire               wr_do   = aw_full && w_full && !s_axi_bvalid;
    wire               wr_b0   = wr_do && wstrb0_h;
    wire  [IRQ_W-1:0]  w1c     = (wr_b0 && aw_idx == REG_IRQ_ST) ? wdata_h[IRQ_W-1:0] : '0;
    wire  [5:0]        ar_idx  = s_axi_araddr[7:2];
    wire               ar_hit  = ar_idx <= REG_PERIOD;
    wire               aw_hit  = aw_idx <= REG_PERIOD;
    wire  [31:0]       rd_mux  = (ar_idx == REG_CTRL)    ? {30'h0, fmt} :
                                 (ar_idx == REG_STATUS)  ? {28'h0, ratio_s, src_osc, lock_fault} :
                                 (ar_idx == REG_IRQ_ST)  ? {29'h0, irq_st} :
                                 (ar_idx == REG_IRQ_MSK) ? {29'h0, irq_msk} :
                                 (ar_idx == REG_PERIOD)  ? {20'h0, period} : 32'h0;

    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready  = !w_full && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign irq           = |(irq_st & irq_msk);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_idx       <= 6'h00;
            wdata_h      <= 32'h0;
            wstrb0_h     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full <= 1'b1;
                aw_idx  <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full   <= 1'b1;
                wdata_h  <= s_axi_wdata;
                wstrb0_h <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                aw_full      <= 1'b0;
                w_full       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= aw_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmt     <= CTRL_RST;
            irq_msk <= '0;
            irq_st  <= '0;
        end else begin
            if (wr_b0 && aw_idx == REG_CTRL)
                fmt <= wdata_h[1:0];
            if (wr_b0 && aw_idx == REG_IRQ_MSK)
                irq_msk <= wdata_h[IRQ_W-1:0];
            irq_st <= (irq_st & ~w1c) | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= ar_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic [9:0] pw;

    always_ff @(posedge aclk) begin
        if (!aresetn)
            pw <= 10'h000;
        else
            pw <= clock_change_pulse ? ((pw != 10'h3FF) ? pw + 10'h001 : pw) : 10'h000;
    end

    chk_reset_levels: assert property (@(posedge aclk) !aresetn |=> (lock_fault && !sys_clk_out && !bit_clk_out && !word_clk_out && !serial_data_out && !clock_change_pulse)) else $error("outputs wrong in reset");
    chk_pulse_width: assert property (@(posedge aclk) disable iff (!aresetn) $fell(clock_change_pulse) |-> (pw >= 10'(PULSE_CYC) && pw <= 10'(PULSE_MAX_CYC))) else $error("clock change pulse width");
    chk_word_edge: assert property (@(posedge aclk) disable iff (!aresetn) $changed(word_clk_out) |-> $fell(bit_clk_out)) else $error("word clock not on bit clock fall");
    chk_data_edge: assert property (@(posedge aclk) disable iff (!aresetn) $changed(serial_data_out) |-> $fell(bit_clk_out)) else $error("data not on bit clock fall");
    chk_word_period: assert property (@(posedge aclk) disable iff (!aresetn) $changed(word_clk_out) |-> bc[4:0] == 5'h00) else $error("word clock not every 32 bits");
    chk_bck_sync: assert property (@(posedge aclk) disable iff (!aresetn) $changed(bit_clk_out) |-> $changed(sys_clk_out)) else $error("bit clock not on system clock edge");
    chk_lock_release: assert property (@(posedge aclk) disable iff (!aresetn) (frame_evt && !loss && lock_cnt == 3'(LOCK_FRAMES - 1)) |=> !lock_fault) else $error("lock fault not released");
    chk_osc_follow: assert property (@(posedge aclk) disable iff (!aresetn) (src_osc && ref_edge) |=> $changed(sys_clk_out)) else $error("system clock ignores reference");

endmodule

// *** bench/bps_sink.sv ***
`timescale 1ns/100ps
module bps_sink (
    // Serial audio in
    input  wire logic        aclk,
    input  wire logic        bit_clk_out,
    input  wire logic        word_clk_out,
    input  wire logic        serial_data_out,
    // Observations
    output logic [7:0]       half_bits,
    output logic [15:0]      bad_edges
);
    logic [7:0] cnt = 8'h00;
    logic       bc_q = 1'b0, wc_q = 1'b0, sd_q = 1'b0;
    initial half_bits = 8'h00;
    initial bad_edges = 16'h0000;
    // ----------------------------------------------------------------
    // Receiver sampling on aclk
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        bc_q <= bit_clk_out;
        wc_q <= word_clk_out;
        sd_q <= serial_data_out;
        if ((word_clk_out != wc_q || serial_data_out != sd_q) && !(bc_q && !bit_clk_out))
            bad_edges <= bad_edges + 16'h0001;
        if (word_clk_out != wc_q) begin
            half_bits <= cnt;
            cnt       <= 8'h00;
        end else if (!bc_q && bit_clk_out)
            cnt <= cnt + 8'h01;
    end
endmodule

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
    import bps_pkg::*;
();
    logic aclk = 1'b0, aresetn = 1'b0, biphase_in = 1'b0, ref_osc_in = 1'b0, clk_source_sel = 1'b0;
    logic [1:0] pll_ratio_sel = 2'h0, s_axi_bresp, s_axi_rresp, r;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, half_bits;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d, rs;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic sys_clk_out, bit_clk_out, word_clk_out, serial_data_out, chan_status_out, user_bit_out;
    logic lock_fault, clock_change_pulse, irq;
    logic [15:0] bad_edges;
    int seed = 66545, err_total = 0, n_tests = 0, n;
    localparam int BP_CELL = 4;
    logic bp_en = 1'b0;
    logic [1:0] bp_ph = 2'h0;
    logic [6:0] bp_ui = 7'h00;
    logic [27:0] bp_sub = 28'h0;
    logic [31:0] bp_rnd;
    wire [7:0] bp_pre = bp_ui[6] ? 8'h69 : 8'h39;
    wire bp_tog = (bp_ui[5:0] < 6'h08) ? bp_pre[bp_ui[2:0]] : (!bp_ui[0] || bp_sub[bp_ui[5:1] - 5'h04]);
    bps_rx_out i_dut (.*);
    bps_sink i_sink (.aclk, .bit_clk_out, .word_clk_out, .serial_data_out, .half_bits, .bad_edges);
    always #10 aclk = ~aclk;
    initial begin
        #3;
        forever #80 ref_osc_in = ~ref_osc_in;
    end
    // ----------------------------------------------------------------
    // Biphase source, four aclk per half cell, 512 aclk per frame
    // ----------------------------------------------------------------
    always @(posedge aclk) begin
        if (bp_en) begin
            bp_ph <= bp_ph + 2'h1;
            if (bp_ph == 2'h0 && bp_tog)
                biphase_in <= ~biphase_in;
            if (bp_ph == 2'h3)
                bp_ui <= bp_ui + 7'h01;
            if (bp_ph == 2'h3 && bp_ui[5:0] == 6'h3F) begin
                bp_rnd = $random(seed);
                bp_sub <= {^{bp_rnd[26:25], bp_rnd[23:0]}, bp_rnd[26:25], 1'b0, bp_rnd[23:0]};
            end
        end
    end
    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            r = s_axi_bresp;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            d = s_axi_rdata;
            r = s_axi_rresp;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // ----------------------------------------------------------------
    // Sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (12) @(posedge aclk);
        chk("reset pins", 32'h1, {clock_change_pulse, irq, sys_clk_out, bit_clk_out, word_clk_out,
            serial_data_out, chan_status_out, user_bit_out, lock_fault});
        aresetn <= 1'b1;
        @(posedge aclk);
        axi_rd({REG_CTRL, 2'h0});
        chk("ctrl reset", 32'h0, d);
        axi_rd({REG_PERIOD, 2'h0});
        chk("period reset", PERIOD_DEF, d);
        axi_rd(8'h40);
        chk("unmapped resp", RESP_SLVERR, r);
        axi_wr({REG_IRQ_MSK, 2'h0}, 32'h4);
        rs = $random(seed);
        pll_ratio_sel <= rs[1:0];
        clk_source_sel <= 1'b1;
        n = 0;
        while (!clock_change_pulse && n < 100) begin
            @(posedge aclk);
            n++;
        end
        chk("irq raised", 32'h1, irq);
        n = 0;
        while (clock_change_pulse && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        chk("pulse width", PULSE_CYC, n);
        axi_rd({REG_IRQ_ST, 2'h0});
        chk("irq status", 32'h4, d & 32'h4);
        axi_wr({REG_IRQ_ST, 2'h0}, 32'h4);
        chk("irq cleared", 32'h0, irq);
        axi_rd({REG_STATUS, 2'h0});
        chk("status", {28'h0, rs[1:0], 2'h3}, d);
        for (int i = 0; i < 4; i++) begin
            axi_wr({REG_CTRL, 2'h0}, {30'h0, rs[3:2] ^ 2'(i)});
            axi_rd({REG_CTRL, 2'h0});
            chk("format", {30'h0, rs[3:2] ^ 2'(i)}, d);
        end
        repeat (8000) @(posedge aclk);
        chk("bits per half", 32'd32, half_bits);
        chk("edge faults", 32'h0, bad_edges);
        bp_en <= 1'b1;
        n = 0;
        while (lock_fault && n < 20000) begin
            @(posedge aclk);
            n++;
        end
        chk("lock", 32'h0, lock_fault);
        clk_source_sel <= 1'b0;
        repeat (6000) @(posedge aclk);
        axi_rd({REG_PERIOD, 2'h0});
        chk("frame period", BP_CELL * 128, d);
        axi_rd({REG_IRQ_ST, 2'h0});
        chk("lock gained", 32'h1, d & 32'h1);
        chk("recovered bits per half", 32'd32, half_bits);
        chk("recovered edge faults", 32'h0, bad_edges);
        give_verdict();
    end
    initial begin
        #1_000_000;
        err_total++;
        give_verdict();
    end
endmodule
